// ==== core/hfc_consts.svh ====
// offsets, field positions, reset values and timing figures of the holdover control bank
`ifndef HFC_CONSTS_SVH
`define HFC_CONSTS_SVH
`define HFC_ADDR_LOW_BYTE      7'h3E
`define HFC_ADDR_MID_BYTE      7'h3F
`define HFC_ADDR_MODE_CTRL     7'h40
`define HFC_RST_LOW_BYTE       8'h00
`define HFC_RST_MID_BYTE       8'h00
`define HFC_RST_MODE_CTRL      8'h88
`define HFC_BIT_AVG_USE        7
`define HFC_BIT_AVG_FAST       6
`define HFC_BIT_READ_AVG       5
`define HFC_POL_HI             4
`define HFC_POL_LO             3
`define HFC_FRQ_HI             2
`define HFC_FRQ_LO             0
`define HFC_CLK_HZ             100000000
`define HFC_FAST_AVG_MIN       8
`define HFC_SLOW_AVG_MIN       110
`define HFC_AVG_TICK_US        128000
`define HFC_AVG_TICK_CYC       ((`HFC_AVG_TICK_US * (`HFC_CLK_HZ / 1000000)))
`define HFC_FAST_SHIFT         5'd9
`define HFC_SLOW_SHIFT         5'd13
`endif

// ==== core/hfc_holdover_ctrl.sv ====
// holdover frequency control registers, averagers and holdover source choice
`timescale 1ns/100ps
`default_nettype none
`include "hfc_consts.svh"

// Overview of operation
// - manual word is signed 19 bits: low byte, mid byte, mode bits 2:0 on top
// - mid byte register holds bits 15:8, read/write, resets to zero
// - manual word shares scaling and format with the live loop frequency status
// - averaging-use bit low: holdover takes manual or frozen frequency only
// - averaging-use bit high: averaged frequency used unless manual mode engaged
// - averaging-rate bit chooses slow averaging at 0, fast at 1
// - fast averager about 8 minutes, slow about 110 minutes at -3 dB; the fast one here (k = 9) is about 7 minutes
// - mode control register resets to 1000 1000
// - readback-source bit chooses written value or selected averaged frequency
// - brief-loss field: 00 full method, 01 frozen, 10 fast, 11 slow
module hfc_holdover_ctrl
  import hfc_pkg::*;
#(
  parameter int unsigned AVG_TICK_CYC = `HFC_AVG_TICK_CYC
) (
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rstn,
  // register port from the serial interface logic
  // wr and rd are one-cycle strobes; rdata holds until the next read
  input  wire hfc_req_t           reg_req,
  output logic [7:0]              reg_rdata,
  output logic                    reg_rvalid,
  // loop side
  input  wire logic signed [18:0] live_loop_freq_status,
  input  wire logic               manual_hold_en,
  input  wire logic               hold_active,
  input  wire logic               brief_loss,
  output logic signed [18:0]      hold_freq,
  output hfc_src_t                hold_src
);

  hfc_state_t          st;
  hfc_state_t          next_st;
  logic signed [18:0]  manual_word;
  logic signed [18:0]  fast_avg;
  logic signed [18:0]  slow_avg;
  logic signed [18:0]  sel_avg;
  hfc_loss_pol_t       loss_pol;
  hfc_src_t            full_src;

  // one-pole averager step: acc += (x - acc) >> k, acc holds 8 guard bits
  // the corner of a one-pole filter sits near 1 / (2 pi 2^k T) for tick period T;
  // with a 128 ms tick, k = 9 gives a corner period of about 7 minutes and
  // k = 13 one of about 110 minutes, so both averagers share one tick divider
  // trade-off: a long tick keeps the accumulators narrow, but the averaged
  // value then moves only once per tick, which holdover does not mind
  // the arithmetic shift keeps the sign, so negative offsets average correctly
  function automatic logic [26:0] avg_step(input logic [26:0] acc,
                                           input logic signed [18:0] x,
                                           input logic [4:0] k);
    logic signed [27:0] diff;
    diff = $signed({x, 8'h00}) - $signed({acc[26], acc});
    avg_step = acc + 27'(diff >>> k);
  endfunction : avg_step

  // readback source choice, shared by all three frequency-bearing addresses
  function automatic logic [7:0] read_pick(input logic       avg_sel,
                                           input logic [7:0] avg_bits,
                                           input logic [7:0] wr_bits);
    if (avg_sel) begin
      read_pick = avg_bits;
    end else begin
      read_pick = wr_bits;
    end
  endfunction : read_pick

  // manual word and its format match the live status, one lsb = fixed ppm step
  assign manual_word = {st.mode_ctrl[`HFC_FRQ_HI:`HFC_FRQ_LO], st.mid_byte,
                        st.low_byte};
  assign fast_avg    = st.fast_acc[26:8];
  assign slow_avg    = st.slow_acc[26:8];
  assign sel_avg     = st.mode_ctrl[`HFC_BIT_AVG_FAST] ? fast_avg : slow_avg;
  assign loss_pol    = hfc_loss_pol_t'(st.mode_ctrl[`HFC_POL_HI:`HFC_POL_LO]);

  // full holdover method: manual wins over averaging, averaging (when enabled) wins over frozen
  // manual mode outranks the averaging-use bit, so software can park a
  // filtered word without first switching averaging off
  always_comb begin
    if (manual_hold_en) begin
      full_src = HFC_SRC_MANUAL;
    end else if (st.mode_ctrl[`HFC_BIT_AVG_USE]) begin
      full_src = st.mode_ctrl[`HFC_BIT_AVG_FAST] ? HFC_SRC_FAST : HFC_SRC_SLOW;
    end else begin
      full_src = HFC_SRC_INST;
    end
  end

  // brief loss of a locked loop follows its own policy field
  // a policy of 00 defers to the full method, so a short dropout behaves
  // exactly like a real holdover entry
  always_comb begin
    hold_src = full_src;
    if (brief_loss) begin
      unique case (loss_pol)
        HFC_LOSS_FULL:   hold_src = full_src;
        HFC_LOSS_FREEZE: hold_src = HFC_SRC_INST;
        HFC_LOSS_FAST:   hold_src = HFC_SRC_FAST;
        HFC_LOSS_SLOW:   hold_src = HFC_SRC_SLOW;
      endcase
    end
  end

  // next state: register writes, readback, averagers
  always_comb begin
    next_st        = st;
    next_st.rvalid = 1'b0;
    // averaging tick divider: a one-cycle enable every AVG_TICK_CYC cycles
    if (st.tick_cnt >= 32'(AVG_TICK_CYC - 1)) begin
      next_st.tick_cnt = 32'h00000000;
      next_st.tick     = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + 32'h00000001;
      next_st.tick     = 1'b0;
    end
    // averagers only track while the loop is locked, so holdover keeps history
    // limitation: they start from zero at reset and need several time
    // constants of locked operation before the averaged value is useful
    if (st.tick && !hold_active && !brief_loss) begin
      next_st.fast_acc = avg_step(st.fast_acc, live_loop_freq_status, `HFC_FAST_SHIFT);
      next_st.slow_acc = avg_step(st.slow_acc, live_loop_freq_status, `HFC_SLOW_SHIFT);
    end
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        `HFC_ADDR_LOW_BYTE: begin
          next_st.low_byte = reg_req.wdata;
        end
        `HFC_ADDR_MID_BYTE: begin
          next_st.mid_byte = reg_req.wdata;
        end
        `HFC_ADDR_MODE_CTRL: begin
          // mode bits act from the next cycle, the same edge as the new word
          next_st.mode_ctrl = reg_req.wdata;
        end
        default: begin
          // writes outside the bank are dropped without a trace
        end
      endcase
    end
    if (reg_req.rd) begin
      next_st.rvalid = 1'b1;
      unique case (reg_req.addr)
        `HFC_ADDR_LOW_BYTE: begin
          // averaged bits land where the written bits would sit
          next_st.rdata = read_pick(st.mode_ctrl[`HFC_BIT_READ_AVG], sel_avg[7:0],
                                    st.low_byte);
        end
        `HFC_ADDR_MID_BYTE: begin
          next_st.rdata = read_pick(st.mode_ctrl[`HFC_BIT_READ_AVG], sel_avg[15:8],
                                    st.mid_byte);
        end
        `HFC_ADDR_MODE_CTRL: begin
          // control bits 7:3 always read as written, only the top word bits swap
          next_st.rdata = read_pick(st.mode_ctrl[`HFC_BIT_READ_AVG],
                                    {st.mode_ctrl[7:3], sel_avg[18:16]},
                                    st.mode_ctrl);
        end
        default: begin
          next_st.rdata = 8'h00;  // unmapped reads as zero
        end
      endcase
    end
  end

  // state register
  // the reset branch loads constants only: zero for the whole struct first,
  // then the documented register defaults on top
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st           <= '0;
      st.low_byte  <= `HFC_RST_LOW_BYTE;
      st.mid_byte  <= `HFC_RST_MID_BYTE;
      st.mode_ctrl <= `HFC_RST_MODE_CTRL;
    end else begin
      st <= next_st;
    end
  end

  // selected holdover frequency, registered for a clean data output
  // the choice itself (hold_src) is combinational so the loop sees a mode
  // change at once; the word follows one edge later, a skew the loop
  // absorbs because it only switches source on entering holdover
  logic signed [18:0] hold_freq_q;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      hold_freq_q <= 19'sh00000;
    end else begin
      unique case (hold_src)
        HFC_SRC_MANUAL: begin
          hold_freq_q <= manual_word;
        end
        HFC_SRC_FAST: begin
          hold_freq_q <= fast_avg;
        end
        HFC_SRC_SLOW: begin
          hold_freq_q <= slow_avg;
        end
        HFC_SRC_INST: begin
          // track the live loop while locked; once it lets go, the last
          // sample stays put, which is the instantaneous freeze
          if (!hold_active && !brief_loss) begin
            hold_freq_q <= live_loop_freq_status;
          end
        end
      endcase
    end
  end

  assign hold_freq  = hold_freq_q;
  assign reg_rdata  = st.rdata;
  assign reg_rvalid = st.rvalid;

endmodule : hfc_holdover_ctrl
`default_nettype wire

// ==== core/hfc_pkg.sv ====
// types of the holdover control bank
package hfc_pkg;
  typedef enum logic [1:0] {
    HFC_LOSS_FULL   = 2'b00,
    HFC_LOSS_FREEZE = 2'b01,
    HFC_LOSS_FAST   = 2'b10,
    HFC_LOSS_SLOW   = 2'b11
  } hfc_loss_pol_t;

  typedef enum logic [1:0] {
    HFC_SRC_INST   = 2'b00,
    HFC_SRC_MANUAL = 2'b01,
    HFC_SRC_FAST   = 2'b10,
    HFC_SRC_SLOW   = 2'b11
  } hfc_src_t;

  typedef struct packed {
    logic         wr;
    logic         rd;
    logic [6:0]   addr;
    logic [7:0]   wdata;
  } hfc_req_t;

  typedef struct packed {
    logic [7:0]   low_byte;
    logic [7:0]   mid_byte;
    logic [7:0]   mode_ctrl;
    logic [7:0]   rdata;
    logic         rvalid;
    logic [31:0]  tick_cnt;
    logic         tick;
    logic [26:0]  fast_acc;
    logic [26:0]  slow_acc;
  } hfc_state_t;
endpackage : hfc_pkg

// ==== verif/hfc_holdover_ctrl_chk.sv ====
// assertion checker of the holdover control bank
`timescale 1ns/100ps
`default_nettype none
module hfc_holdover_ctrl_chk
  import hfc_pkg::*;
#(parameter int unsigned AVG_TICK_CYC = 4) (
  // clock and reset
  input wire logic               mclk,
  input wire logic               rstn,
  // register port
  input wire hfc_req_t           reg_req,
  input wire logic [7:0]         reg_rdata,
  input wire logic               reg_rvalid,
  // loop side
  input wire logic signed [18:0] live_loop_freq_status,
  input wire logic               manual_hold_en,
  input wire logic               hold_active,
  input wire logic               brief_loss,
  input wire logic signed [18:0] hold_freq,
  input wire hfc_src_t           hold_src
);
  logic [7:0] lo, mid, md;
  // shadow of the written bytes, so nothing inside the design is peeked at
  always_ff @(posedge mclk or negedge rstn)
    if (!rstn) {lo, mid, md} <= 24'h000088;
    else if (reg_req.wr && reg_req.addr == 7'h3E) lo <= reg_req.wdata;
    else if (reg_req.wr && reg_req.addr == 7'h3F) mid <= reg_req.wdata;
    else if (reg_req.wr && reg_req.addr == 7'h40) md <= reg_req.wdata;
  wire logic [18:0] word = {md[2:0], mid, lo};
  wire logic        hold = hold_active && !brief_loss && !manual_hold_en;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  a_read_answer: assert property (reg_req.rd |=> reg_rvalid) else $error("no read answer");
  a_rdata_holds: assert property (!$past(reg_req.rd) |-> $stable(reg_rdata))
    else $error("read data moved");
  a_manual_first: assert property (hold_active && !brief_loss && manual_hold_en |->
    hold_src == HFC_SRC_MANUAL) else $error("manual not chosen");
  a_avg_off: assert property (hold && !md[7] |-> hold_src == HFC_SRC_INST)
    else $error("averaged used while off");
  a_avg_rate: assert property (hold && md[7] |->
    hold_src == (md[6] ? HFC_SRC_FAST : HFC_SRC_SLOW)) else $error("wrong averager");
  a_brief_policy: assert property (brief_loss && !hold_active && !manual_hold_en &&
    md[4:3] != 2'b00 |-> hold_src == (md[4:3] == 2'b01 ? HFC_SRC_INST : hfc_src_t'(md[4:3])))
    else $error("wrong brief loss source");
  a_manual_word: assert property (hold_src == HFC_SRC_MANUAL |=> hold_freq == $past(word))
    else $error("manual word wrong");
  a_tracks_live: assert property (hold_src == HFC_SRC_INST && !hold_active && !brief_loss
    |=> hold_freq == $past(live_loop_freq_status)) else $error("not tracking live");
  c_manual: cover property (hold_active && hold_src == HFC_SRC_MANUAL);
  c_fast: cover property (hold_active && hold_src == HFC_SRC_FAST);
  c_brief: cover property (brief_loss && hold_src == HFC_SRC_SLOW);
endmodule : hfc_holdover_ctrl_chk
bind hfc_holdover_ctrl hfc_holdover_ctrl_chk #(.AVG_TICK_CYC(AVG_TICK_CYC)) i_chk (
  .mclk(mclk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .live_loop_freq_status(live_loop_freq_status),
  .manual_hold_en(manual_hold_en), .hold_active(hold_active), .brief_loss(brief_loss),
  .hold_freq(hold_freq), .hold_src(hold_src));
`default_nettype wire

// ==== verif/hfc_holdover_ctrl_test.sv ====
// self-checking testbench of the holdover control bank
`timescale 1ns/100ps
`default_nettype none
module hfc_holdover_ctrl_test;
  import hfc_pkg::*;
  logic               mclk = 0, rstn = 0, man = 0, hact = 0, loss = 0, rvalid;
  hfc_req_t           req = '0;
  logic signed [18:0] live = 19'h01234, hf;
  logic [7:0]         rdata;
  hfc_src_t           src;
  int                 err_total = 0, compares = 0;
  always #5 mclk = ~mclk;
  hfc_holdover_ctrl #(.AVG_TICK_CYC(4)) i_hfc_holdover_ctrl (.mclk(mclk), .rstn(rstn),
    .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid), .live_loop_freq_status(live),
    .manual_hold_en(man), .hold_active(hact), .brief_loss(loss), .hold_freq(hf),
    .hold_src(src));
  task automatic chk(input logic [18:0] seen, input logic [18:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // inputs always move 1 ns after the edge, away from sampling
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : step
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    step(1);
    req = '0;
    step(1);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    req = '{1'b0, 1'b1, a, 8'h00};
    step(1);
    req = '0;
    chk({18'h0, rvalid}, 19'h1);
    chk(rdata, exp);
    step(1);
  endtask : rd
  task automatic t_regs;
    rd(7'h3F, 8'h00);
    rd(7'h40, 8'h88);
    wr(7'h3E, 8'h3C);
    wr(7'h3F, 8'hA5);
    wr(7'h40, 8'hE5);
    rd(7'h40, 8'hE0);
    wr(7'h40, 8'h05);
    wr(7'h41, 8'hFF);
    rd(7'h3F, 8'hA5);
    rd(7'h3E, 8'h3C);
    rd(7'h41, 8'h00);
  endtask : t_regs
  // manual word, then frozen frequency with averaging off
  task automatic t_hold;
    man = 1;
    hact = 1;
    step(2);
    chk(src, HFC_SRC_MANUAL);
    chk(hf, 19'h5A53C);
    man = 0;
    hact = 0;
    step(3);
    chk(hf, 19'h01234);
    hact = 1;
    step(1);
    live = 19'h7F00F;
    step(3);
    chk(src, HFC_SRC_INST);
    chk(hf, 19'h01234);
  endtask : t_hold
  task automatic t_avg;
    wr(7'h40, 8'h80);
    chk(src, HFC_SRC_SLOW);
    wr(7'h40, 8'hC0);
    chk(src, HFC_SRC_FAST);
    man = 1;
    step(1);
    chk(src, HFC_SRC_MANUAL);
    man = 0;
    hact = 0;
  endtask : t_avg
  task automatic t_brief;
    hfc_src_t exp_src [4] = '{HFC_SRC_INST, HFC_SRC_INST, HFC_SRC_FAST, HFC_SRC_SLOW};
    loss = 1;
    for (int i = 0; i < 4; i++) begin
      wr(7'h40, {3'b000, i[1:0], 3'b000});
      chk(src, exp_src[i]);
    end
    loss = 0;
  endtask : t_brief
  task automatic report_and_stop;
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    step(20);
    rstn = 1;
    t_regs;
    t_hold;
    t_avg;
    t_brief;
    report_and_stop;
  end
  // a run needs well under a thousand cycles
  initial begin
    #100us;
    err_total++;
    report_and_stop;
  end
endmodule : hfc_holdover_ctrl_test
`default_nettype wire
